// ---- ssf_engine.sv ----
/*
  ssf_engine: slave serial command engine for a one-page scratch flash.
  assumes serial clock, select and data come from an outside master and
  are sampled by mclk; the flash array is modelled as flip-flops.
*/
`timescale 1ns/1ns
module ssf_engine (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic serialClk,
  input  wire logic chipSelectN,
  input  wire logic serialIn,
  input  wire logic portBlocked,
  output logic      serialOut,
  output logic      serialOutEn,
  output logic      programDoneFlag,
  output logic      programEnabled
);
  logic sclkS, csS, siS;
  ssf_sync uSclk (.mclk(mclk), .rst(rst), .pinIn(serialClk),   .pinOut(sclkS));
  ssf_sync uCs   (.mclk(mclk), .rst(rst), .pinIn(chipSelectN), .pinOut(csS));
  ssf_sync uSi   (.mclk(mclk), .rst(rst), .pinIn(serialIn),    .pinOut(siS));

  logic                            sclkPrev_q, csPrev_q;
  logic [5:0]                      bitCnt_q;
  logic [7:0]                      opcode_q;
  logic                            opValid_q;
  logic                            latch_q;
  logic [ssf_pkg::PAGE_BITS-1:0]   buffer_q;
  logic [ssf_pkg::PAGE_BITS-1:0]   flash_q;
  logic [31:0]                     idShift_q;
  logic [1:0]                      pendOp_q;
  logic [1:0]                      execCnt_q;
  logic [1:0]                      nvmState_q;
  logic [31:0]                     nvmCnt_q;
  logic                            doneFlag_q;
  logic                            soData_q, soEn_q;
  logic [8:0]                      progCnt_q;

  wire rise      = sclkS & ~sclkPrev_q;
  wire fall      = ~sclkS & sclkPrev_q;
  wire selected  = ~csS & ~portBlocked;
  wire csRise    = csS & ~csPrev_q;
  wire inHeader  = bitCnt_q < ssf_pkg::HEADER_BITS;
  wire [7:0] opNext = {opcode_q[6:0], siS};
  wire opDoneNow = rise & (bitCnt_q == ssf_pkg::OPCODE_BITS - 6'd1);
  wire isId      = opValid_q & (opcode_q == ssf_pkg::OP_READ_IDENTITY_CMD);
  wire isRead    = opValid_q & (opcode_q == ssf_pkg::OP_READ_PAGE);
  wire isProg    = opValid_q & (opcode_q == ssf_pkg::OP_PROGRAM) & latch_q;
  wire isStatus  = opValid_q & (opcode_q == ssf_pkg::OP_STATUS) & latch_q;
  wire nvmBusy   = nvmState_q != ssf_pkg::NVM_IDLE;
  wire execReady = opValid_q & (bitCnt_q >= ssf_pkg::HEADER_BITS);
  wire knownOp   = (opNext == ssf_pkg::OP_READ_IDENTITY_CMD) | (opNext == ssf_pkg::OP_PROG_EN)
                 | (opNext == ssf_pkg::OP_PROG_DIS) | (opNext == ssf_pkg::OP_ERASE)
                 | (opNext == ssf_pkg::OP_PROGRAM) | (opNext == ssf_pkg::OP_READ_PAGE)
                 | (opNext == ssf_pkg::OP_STATUS);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else begin
      sclkPrev_q <= sclkS;
      csPrev_q   <= csS;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !selected) begin
      bitCnt_q  <= 6'd0;
      opcode_q  <= 8'h00;
      opValid_q <= 1'b0;
    end else if (rise) begin
      if (inHeader) begin
        bitCnt_q <= bitCnt_q + 6'd1;
      end
      if (bitCnt_q < ssf_pkg::OPCODE_BITS) begin
        opcode_q <= opNext;
      end
      if (opDoneNow) begin
        opValid_q <= knownOp;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pendOp_q        <= 2'd0;
      execCnt_q       <= 2'd0;
      latch_q         <= 1'b0;
    end else if (csRise && execReady) begin
      execCnt_q <= 2'd0;
      if (opcode_q == ssf_pkg::OP_PROG_EN) begin
        pendOp_q <= 2'd1;
      end else if (opcode_q == ssf_pkg::OP_PROG_DIS) begin
        pendOp_q <= 2'd2;
      end else if (opcode_q == ssf_pkg::OP_ERASE && latch_q && !nvmBusy) begin
        pendOp_q <= 2'd3;
      end else if (isProg && progCnt_q == 9'(ssf_pkg::PAGE_BITS) && !nvmBusy) begin
        pendOp_q <= 2'd3;
      end else begin
        pendOp_q <= 2'd0;
      end
    end else if (pendOp_q != 2'd0 && rise && csS) begin
      if (execCnt_q == ssf_pkg::EXEC_CLOCKS - 2'd1) begin
        pendOp_q <= 2'd0;
        if (pendOp_q == 2'd1) begin
          latch_q <= 1'b1;
        end
        if (pendOp_q == 2'd2) begin
          latch_q <= 1'b0;
        end
      end else begin
        execCnt_q <= execCnt_q + 2'd1;
      end
    end
  end

  logic       progStart;
  logic       startIsErase_q;
  assign progStart = (pendOp_q == 2'd3) & rise & csS
                   & (execCnt_q == ssf_pkg::EXEC_CLOCKS - 2'd1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      startIsErase_q <= 1'b0;
    end else if (csRise && execReady) begin
      startIsErase_q <= opcode_q == ssf_pkg::OP_ERASE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      nvmState_q <= ssf_pkg::NVM_IDLE;
      nvmCnt_q   <= 32'd0;
      doneFlag_q <= 1'b1;
      flash_q    <= '1;
    end else begin
      case (nvmState_q)
        ssf_pkg::NVM_IDLE: begin
          if (progStart) begin
            nvmState_q <= startIsErase_q ? ssf_pkg::NVM_ERASE : ssf_pkg::NVM_PROG;
            nvmCnt_q   <= startIsErase_q ? 32'(ssf_pkg::ERASE_CYCLES)
                                         : 32'(ssf_pkg::PROG_CYCLES);
            doneFlag_q <= 1'b0;
          end
        end
        ssf_pkg::NVM_ERASE: begin
          if (nvmCnt_q <= 32'd1) begin
            flash_q    <= '1;
            doneFlag_q <= 1'b1;
            nvmState_q <= ssf_pkg::NVM_IDLE;
          end else begin
            nvmCnt_q <= nvmCnt_q - 32'd1;
          end
        end
        ssf_pkg::NVM_PROG: begin
          if (nvmCnt_q <= 32'd1) begin
            flash_q    <= buffer_q;
            doneFlag_q <= 1'b1;
            nvmState_q <= ssf_pkg::NVM_IDLE;
          end else begin
            nvmCnt_q <= nvmCnt_q - 32'd1;
          end
        end
        default: begin
          nvmState_q <= ssf_pkg::NVM_IDLE;
        end
      endcase
    end
  end

  wire xferNow = selected & rise & isRead & (bitCnt_q == ssf_pkg::XFER_START_BIT - 6'd1);
  wire dataPhase = opValid_q & ~inHeader;

  // read transfer on third dummy clock
  // fast read needs no extra wait
  always_ff @(posedge mclk) begin
    if (rst) begin
      buffer_q  <= '0;
      progCnt_q <= 9'd0;
    end else if (xferNow && !nvmBusy) begin
      buffer_q <= flash_q;
    end else if (selected && rise && dataPhase && isProg) begin
      buffer_q <= {siS, buffer_q[ssf_pkg::PAGE_BITS-1:1]};
      if (progCnt_q <= 9'(ssf_pkg::PAGE_BITS)) begin
        progCnt_q <= progCnt_q + 9'd1;
      end
    end else if (selected && fall && dataPhase && isRead) begin
      buffer_q <= {1'b0, buffer_q[ssf_pkg::PAGE_BITS-1:1]};
    end else if (selected && opDoneNow) begin
      progCnt_q <= 9'd0;
    end
  end

  // identity after clock 31, counted from 0
  always_ff @(posedge mclk) begin
    if (rst || !selected) begin
      soEn_q    <= 1'b0;
      soData_q  <= 1'b0;
      idShift_q <= ssf_pkg::IDENTITY_WORD;
    end else if (fall) begin
      if (isId && bitCnt_q > ssf_pkg::ID_ENABLE_BIT) begin
        soEn_q    <= 1'b1;
        soData_q  <= idShift_q[0];
        idShift_q <= {1'b0, idShift_q[31:1]};
      end else if (isRead && dataPhase) begin
        soEn_q   <= 1'b1;
        soData_q <= buffer_q[0];
      end else if (isStatus && dataPhase) begin
        soEn_q   <= 1'b1;
        soData_q <= ~soEn_q ? doneFlag_q : 1'b0;
      end
    end
  end

  assign serialOut       = soData_q;
  assign serialOutEn     = soEn_q;
  assign programDoneFlag = doneFlag_q;
  assign programEnabled  = latch_q;

  a_blocked_quiet: assert property (@(posedge mclk) disable iff (rst)
    portBlocked |=> ##1 !serialOutEn) else $error("output driven while port blocked");
  a_desel_float: assert property (@(posedge mclk) disable iff (rst)
    csS |=> !serialOutEn) else $error("output driven while deselected");
  a_prog_float: assert property (@(posedge mclk) disable iff (rst)
    isProg |-> !serialOutEn) else $error("output driven during program");
  a_erase_flag: assert property (@(posedge mclk) disable iff (rst)
    (progStart && startIsErase_q) |=> !programDoneFlag && nvmState_q == ssf_pkg::NVM_ERASE)
    else $error("erase start did not clear flag");
  a_busy_flag: assert property (@(posedge mclk) disable iff (rst)
    nvmBusy |-> !programDoneFlag) else $error("flag high while busy");
  a_no_abort: assert property (@(posedge mclk) disable iff (rst)
    (nvmBusy && nvmCnt_q > 32'd1) |=> nvmBusy) else $error("operation aborted");
  a_latch_gate: assert property (@(posedge mclk) disable iff (rst)
    (progStart) |-> latch_q) else $error("erase or program without latch");
  a_latch_hold: assert property (@(posedge mclk) disable iff (rst)
    ($fell(latch_q)) |-> $past(pendOp_q) == 2'd2) else $error("latch cleared without disable");
  a_id_wait: assert property (@(posedge mclk) disable iff (rst)
    (isId && inHeader) |-> !serialOutEn) else $error("identity driven inside header");
  a_latch_clear: assert property (@(posedge mclk) disable iff (rst)
    (pendOp_q == 2'd2 && rise && csS && execCnt_q == ssf_pkg::EXEC_CLOCKS - 2'd1)
    |=> !programEnabled) else $error("disable left latch set");
  a_unknown_quiet: assert property (@(posedge mclk) disable iff (rst)
    !opValid_q |-> !serialOutEn) else $error("output driven without a known opcode");
  a_full_page: assert property (@(posedge mclk) disable iff (rst)
    (progStart && !startIsErase_q) |-> progCnt_q == 9'(ssf_pkg::PAGE_BITS))
    else $error("program started on a partial page");
  a_done_set: assert property (@(posedge mclk) disable iff (rst)
    (nvmBusy && nvmCnt_q <= 32'd1) |=> programDoneFlag && !nvmBusy)
    else $error("flag not set at end of operation");
endmodule

// ---- ssf_pkg.sv ----
/*
  ssf_pkg: opcodes, bit counts, page size and timing for the scratch flash
  serial engine. assumes mclk runs at CLK_MHZ, 125 MHz, for the erase and program cycle counts.
*/
package ssf_pkg;
  localparam int          PAGE_BITS      = 128;
  localparam logic [7:0]  OP_READ_IDENTITY_CMD     = 8'h98;
  localparam logic [7:0]  OP_PROG_EN     = 8'hac;
  localparam logic [7:0]  OP_PROG_DIS    = 8'h78;
  localparam logic [7:0]  OP_ERASE       = 8'h0e;
  localparam logic [7:0]  OP_PROGRAM     = 8'h8e;
  localparam logic [7:0]  OP_READ_PAGE   = 8'h4e;
  localparam logic [7:0]  OP_STATUS      = 8'h4a;
  localparam logic [5:0]  OPCODE_BITS    = 6'd8;
  localparam logic [5:0]  XFER_START_BIT = 6'd11;
  localparam logic [5:0]  HEADER_BITS    = 6'd32;
  localparam logic [5:0]  ID_ENABLE_BIT  = 6'd31;
  localparam logic [1:0]  EXEC_CLOCKS    = 2'd3;
  // value is arbitrary
  localparam logic [31:0] IDENTITY_WORD  = 32'h5a3c_96e1;
  localparam int          ERASE_TIME_US  = 100;
  localparam int          PROG_TIME_US   = 100;
  localparam int          CLK_MHZ        = 125;
  localparam int          ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
  localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam logic [1:0]  NVM_IDLE       = 2'b00;
  localparam logic [1:0]  NVM_ERASE      = 2'b01;
  localparam logic [1:0]  NVM_PROG       = 2'b11;
endpackage

// ---- ssf_sync.sv ----
/*
  ssf_sync: two-stage synchroniser for one pin level.
  assumes the input is asynchronous to mclk.
*/
`timescale 1ns/1ns
module ssf_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      pinOut
);
  logic stage1_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_q <= 1'b1;
      pinOut   <= 1'b1;
    end else begin
      stage1_q <= pinIn;
      pinOut   <= stage1_q;
    end
  end
endmodule

// ---- ssf_spi_master.sv ----
/*
  ssf_spi_master: behavioural serial master facing the scratch flash engine.
  assumes mode 0 and a 125 ns serial clock with no fixed phase to mclk.
*/
`timescale 1ns/1ns
module ssf_spi_master (
  output logic      serialClk,
  output logic      chipSelectN,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  logic soLine;
  assign soLine = serialOutEn ? serialOut : 1'bz;
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end
  task automatic pulse(output logic so, output logic en);
    #62 serialClk = 1'b1;
    so = soLine;
    en = serialOutEn;
    #63 serialClk = 1'b0;
  endtask
  task automatic reset_iface();
    #100 chipSelectN = 1'b0;
    #100 chipSelectN = 1'b1;
    #200;
  endtask
  task automatic frame(input logic [7:0] op, input int nData, input logic [127:0] din,
                       output logic [127:0] dout, output logic [127:0] den, output int hdrEn);
    logic so;
    logic en;
    hdrEn = 0;
    dout = '0;
    den = '0;
    chipSelectN = 1'b0;
    for (int i = 0; i < 32 + nData; i++) begin
      serialIn = (i < 8) ? op[7 - i] : (i < 32) ? i[0] : din[7'(i - 32)];
      pulse(so, en);
      if (i < 32) hdrEn += int'(en);
      else if (i < 160) begin
        dout[7'(i - 32)] = so;
        den[7'(i - 32)] = en;
      end
      if (op == ssf_pkg::OP_READ_PAGE && i == 10) #5000;
    end
    #62 serialIn = ~serialIn;
    chipSelectN = 1'b1;
    repeat (3) pulse(so, en);
    #200;
  endtask
endmodule

// ---- test_ssf_engine.sv ----
/*
  test_ssf_engine: self-checking bench for the scratch flash serial engine.
  assumes the master model drives the serial pins; mclk runs at 125 MHz.
*/
`timescale 1ns/1ns
module test_ssf_engine;
  logic         mclk;
  logic         rst;
  logic         portBlocked;
  logic         serialClk;
  logic         chipSelectN;
  logic         serialIn;
  logic         serialOut;
  logic         serialOutEn;
  logic         programDoneFlag;
  logic         programEnabled;
  logic [127:0] rd;
  logic [127:0] en;
  logic [127:0] pat;
  int           he;
  int           fail_count;
  int           n_checks;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ssf_engine u_dut (.mclk(mclk), .rst(rst), .serialClk(serialClk), .chipSelectN(chipSelectN),
    .serialIn(serialIn), .portBlocked(portBlocked), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .programDoneFlag(programDoneFlag),
    .programEnabled(programEnabled));
  ssf_spi_master u_master (.serialClk(serialClk), .chipSelectN(chipSelectN),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn));
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input logic [127:0] d);
    u_master.frame(op, n, d, rd, en, he);
  endtask
  task automatic t_locked();
    cmd(8'h00, 8, '1);
    chk("unknown oe", en | 128'(he), '0);
    cmd(ssf_pkg::OP_STATUS, 8, '0);
    chk("locked status oe", 128'(en[0]), '0);
    cmd(ssf_pkg::OP_ERASE, 0, '0);
    chk("locked erase", 128'(programDoneFlag), 128'd1);
    @(posedge mclk) portBlocked <= 1'b1;
    cmd(ssf_pkg::OP_PROG_EN, 0, '0);
    chk("blocked enable", 128'(programEnabled), '0);
    @(posedge mclk) portBlocked <= 1'b0;
    $display("test locked done");
  endtask
  task automatic t_identity();
    cmd(ssf_pkg::OP_READ_IDENTITY_CMD, 40, '1);
    chk("id word", 128'(rd[31:0]), 128'(ssf_pkg::IDENTITY_WORD));
    chk("id header oe", 128'(he), '0);
    chk("id dummy", 128'(rd[39:32]), '0);
    chk("id oe", 128'(en[39:0]), 128'({40{1'b1}}));
    $display("test identity done");
  endtask
  task automatic t_enable();
    cmd(ssf_pkg::OP_PROG_EN, 5, '0);
    chk("latch set", 128'(programEnabled), 128'd1);
    cmd(ssf_pkg::OP_STATUS, 8, '0);
    chk("status idle", 128'({en[0], rd[0]}), 128'd3);
    $display("test enable done");
  endtask
  task automatic t_program();
    int k;
    pat = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    cmd(ssf_pkg::OP_PROGRAM, 128, pat);
    chk("program oe", en | 128'(he), '0);
    chk("program busy", 128'(programDoneFlag), '0);
    cmd(ssf_pkg::OP_STATUS, 8, '0);
    chk("status busy", 128'({en[0], rd[0]}), 128'd2);
    for (k = 0; k < ssf_pkg::PROG_CYCLES + 1000 && programDoneFlag !== 1'b1; k++)
      @(posedge mclk);
    chk("program done", 128'(programDoneFlag), 128'd1);
    if (k == ssf_pkg::PROG_CYCLES + 1000) wrap_up();
    cmd(ssf_pkg::OP_READ_PAGE, 128, '1);
    chk("page readback", rd, pat);
    $display("test program done");
  endtask
  task automatic t_disable();
    cmd(ssf_pkg::OP_PROG_DIS, 0, '0);
    chk("latch clear", 128'(programEnabled), '0);
    cmd(ssf_pkg::OP_READ_PAGE, 128, '0);
    chk("read while locked", rd, pat);
    cmd(ssf_pkg::OP_PROGRAM, 128, ~pat);
    chk("program locked", 128'(programDoneFlag), 128'd1);
    $display("test disable done");
  endtask
  task automatic t_erase();
    int k;
    cmd(ssf_pkg::OP_PROG_EN, 0, '0);
    cmd(ssf_pkg::OP_ERASE, 0, '0);
    chk("erase busy", 128'(programDoneFlag), '0);
    cmd(ssf_pkg::OP_PROG_DIS, 0, '0);
    chk("erase no abort", 128'(programDoneFlag), '0);
    for (k = 0; k < ssf_pkg::ERASE_CYCLES + 1000 && programDoneFlag !== 1'b1; k++)
      @(posedge mclk);
    chk("erase done", 128'(programDoneFlag), 128'd1);
    if (k == ssf_pkg::ERASE_CYCLES + 1000) wrap_up();
    cmd(ssf_pkg::OP_READ_PAGE, 128, '0);
    chk("erased page", rd, '1);
    $display("test erase done");
  endtask
  initial begin
    rst = 1'b1;
    portBlocked = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #3;
    u_master.reset_iface();
    t_locked();
    t_identity();
    t_enable();
    t_program();
    t_disable();
    t_erase();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    wrap_up();
  end
endmodule
